//--- rtl/phase_sign_regs.sv
/*
 * apb register bank holding per-phase phase compensation codes and the
 * power sign status, with pulse-path selection registers and a sign
 * change interrupt.
 * assumes the power datapath runs on clk_i and pulses new_result_i for one
 * cycle with a stable sample set; the apb master shares clk_i.
 */
// Implementation choice: the APB slave port.
module phase_sign_regs #(
	parameter bit HAS_REACTIVE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire phase_sign_pkg::apb_req_t apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire phase_sign_pkg::power_set_t power_i,
	input wire logic new_result_i,
	output phase_sign_pkg::comp_set_t comp_effective_o,
	output logic [phase_sign_pkg::REG_W-1:0] pulse_mode_o,
	output logic [phase_sign_pkg::REG_W-1:0] compensation_mode_o,
	output logic irq_o
);
	import phase_sign_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic reg_sel_t decode_reg(input logic [PADDR_W-1:0] addr);
		logic [15:0] idx;
		idx = addr[PADDR_W-1:2];
		if (addr[1:0] != 2'b00) begin
			decode_reg = SEL_NONE;
		end else if (idx == PHASE_A_PHASE_COMP_IDX) begin
			decode_reg = SEL_COMP_A;
		end else if (idx == PHASE_B_PHASE_COMP_IDX) begin
			decode_reg = SEL_COMP_B;
		end else if (idx == PHASE_C_PHASE_COMP_IDX) begin
			decode_reg = SEL_COMP_C;
		end else if (idx == POWER_SIGN_STATUS_IDX) begin
			decode_reg = SEL_SIGN;
		end else if (idx == ACCUMULATION_MODE_IDX) begin
			decode_reg = SEL_ACC_MODE;
		end else if (idx == COMPENSATION_MODE_IDX) begin
			decode_reg = SEL_COMP_MODE;
		end else if (idx == PULSE_MODE_IDX) begin
			decode_reg = SEL_PULSE_MODE;
		end else if (idx == IRQ_STATUS_IDX) begin
			decode_reg = SEL_IRQ_STATUS;
		end else if (idx == IRQ_ENABLE_IDX) begin
			decode_reg = SEL_IRQ_ENABLE;
		end else if (idx == IRQ_CLEAR_IDX) begin
			decode_reg = SEL_IRQ_CLEAR;
		end else begin
			decode_reg = SEL_NONE;
		end
	endfunction

	// out-of-range codes fold onto the range the filter really has
	function automatic logic [COMP_W-1:0] fold_comp(input logic [COMP_W-1:0] code);
		logic [COMP_W-1:0] diff;
		diff = code - ALIAS_HIGH_BASE;
		if (code <= LEAD_MAX) begin
			fold_comp = code;
		end else if (code <= ALIAS_LOW_MAX) begin
			fold_comp = code - ALIAS_LOW_SHIFT;
		end else if (code <= LAG_MAX) begin
			fold_comp = code;
		end else begin
			fold_comp = ALIAS_HIGH_TARGET + {3'h0, diff[6:0]};
		end
	endfunction

	function automatic logic signed [POWER_W-1:0] pick_power(input phase_power_t p,
			input logic [2:0] kind);
		case (kind)
			POWER_TOTAL_ACTIVE: pick_power = p.total_active;
			POWER_TOTAL_REACTIVE: pick_power = HAS_REACTIVE ? p.total_reactive : '0;
			POWER_APPARENT: pick_power = p.apparent;
			POWER_FUND_ACTIVE: pick_power = p.fund_active;
			POWER_FUND_REACTIVE: pick_power = HAS_REACTIVE ? p.fund_reactive : '0;
			default: pick_power = '0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// apb access qualification
	// ----------------------------------------------------------------
	// one wait state keeps prdata and pready straight from flip-flops
	reg_sel_t sel;
	logic access;
	logic wr_take;
	logic rd_take;

	assign sel = decode_reg(apb_i.paddr);
	assign access = apb_i.psel && apb_i.penable && !pready_o;
	assign wr_take = apb_i.psel && apb_i.penable && pready_o && apb_i.pwrite && !pslverr_o;
	assign rd_take = access && !apb_i.pwrite;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= access;
			// write-only clear register refuses reads, unmapped or misaligned addresses refuse both, the rest is plain
			pslverr_o <= access && ((sel == SEL_NONE)
				|| (sel == SEL_IRQ_CLEAR && !apb_i.pwrite));
		end
	end

	// ----------------------------------------------------------------
	// phase compensation registers
	// ----------------------------------------------------------------
	logic [2:0][COMP_W-1:0] comp_code;

	generate
		for (genvar ph = 0; ph < 3; ph++) begin : g_comp
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					comp_code[ph] <= COMP_RESET;
					comp_effective_o[ph] <= COMP_RESET;
				end else begin
					if (wr_take && sel == reg_sel_t'(ph)) begin
						// bits 15:10 are not stored; software keeps to the
						// lead or lag window, anything else still folds
						comp_code[ph] <= apb_i.pwdata[COMP_W-1:0];
					end
					comp_effective_o[ph] <= fold_comp(comp_code[ph]);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// mode registers
	// ----------------------------------------------------------------
	logic [REG_W-1:0] accumulation_mode_reg;
	logic [REG_W-1:0] compensation_mode_reg;
	logic [REG_W-1:0] pulse_mode_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accumulation_mode_reg <= ACCUMULATION_MODE_RESET;
			compensation_mode_reg <= COMPENSATION_MODE_RESET;
			pulse_mode_reg <= PULSE_MODE_RESET;
		end else if (wr_take) begin
			if (sel == SEL_ACC_MODE) begin
				accumulation_mode_reg <= apb_i.pwdata[REG_W-1:0];
			end else if (sel == SEL_COMP_MODE) begin
				compensation_mode_reg <= apb_i.pwdata[REG_W-1:0];
			end else if (sel == SEL_PULSE_MODE) begin
				pulse_mode_reg <= apb_i.pwdata[REG_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_mode_o <= PULSE_MODE_RESET;
			compensation_mode_o <= COMPENSATION_MODE_RESET;
		end else begin
			pulse_mode_o <= pulse_mode_reg;
			compensation_mode_o <= compensation_mode_reg;
		end
	end

	// ----------------------------------------------------------------
	// sign evaluation
	// ----------------------------------------------------------------
	logic [SIGN_W-1:0] next_sign;
	logic [2:0] path_negative;

	generate
		for (genvar k = 0; k < 3; k++) begin : g_path
			logic signed [SUM_W-1:0] path_sum;
			logic [2:0] kind;
			logic [2:0] terms;
			assign kind = pulse_mode_reg[3*k+2 -: 3];
			assign terms = compensation_mode_reg[3*k+2 -: 3];
			// reserved power types contribute nothing, so the sum reads positive
			always_comb begin
				path_sum = '0;
				for (int ph = 0; ph < 3; ph++) begin
					if (terms[ph]) begin
						path_sum = path_sum + SUM_W'(pick_power(power_i[ph], kind));
					end
				end
			end
			assign path_negative[k] = path_sum[SUM_W-1];
		end
	endgenerate

	always_comb begin
		next_sign = SIGN_RESET;
		for (int ph = 0; ph < 3; ph++) begin
			// zero power counts as positive
			next_sign[ph] = accumulation_mode_reg[ACTIVE_REVERSAL_SELECT_BIT]
				? power_i[ph].fund_active[POWER_W-1]
				: power_i[ph].total_active[POWER_W-1];
			next_sign[ph+4] = HAS_REACTIVE && (accumulation_mode_reg[REACTIVE_REVERSAL_SELECT_BIT]
				? power_i[ph].fund_reactive[POWER_W-1]
				: power_i[ph].total_reactive[POWER_W-1]);
		end
		next_sign[SUM_ONE_BIT] = path_negative[0];
		next_sign[SUM_TWO_BIT] = path_negative[1];
		next_sign[SUM_THREE_BIT] = path_negative[2];
	end

	// ----------------------------------------------------------------
	// power sign status
	// ----------------------------------------------------------------
	logic [SIGN_W-1:0] power_sign_status;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_sign_status <= SIGN_RESET;
		end else if (new_result_i) begin
			// apb writes never reach this register
			power_sign_status <= next_sign;
		end
	end

	// ----------------------------------------------------------------
	// sign change interrupt
	// ----------------------------------------------------------------
	logic [SIGN_W-1:0] irq_status;
	logic [SIGN_W-1:0] irq_enable;
	logic [SIGN_W-1:0] sign_event;
	logic [SIGN_W-1:0] clear_mask;

	assign sign_event = new_result_i ? (next_sign ^ power_sign_status) : '0;
	assign clear_mask = (wr_take && sel == SEL_IRQ_CLEAR) ? apb_i.pwdata[SIGN_W-1:0] : '0;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status <= SIGN_RESET;
		end else begin
			// a change in the clearing cycle survives the clear
			irq_status <= (irq_status & ~clear_mask) | sign_event;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_enable <= SIGN_RESET;
		end else if (wr_take && sel == SEL_IRQ_ENABLE) begin
			irq_enable <= apb_i.pwdata[SIGN_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (rd_take) begin
			if (sel == SEL_COMP_A) begin
				prdata_o <= {22'h000000, comp_code[0]};
			end else if (sel == SEL_COMP_B) begin
				prdata_o <= {22'h000000, comp_code[1]};
			end else if (sel == SEL_COMP_C) begin
				prdata_o <= {22'h000000, comp_code[2]};
			end else if (sel == SEL_SIGN) begin
				prdata_o <= {23'h000000, power_sign_status};
			end else if (sel == SEL_ACC_MODE) begin
				prdata_o <= {16'h0000, accumulation_mode_reg};
			end else if (sel == SEL_COMP_MODE) begin
				prdata_o <= {16'h0000, compensation_mode_reg};
			end else if (sel == SEL_PULSE_MODE) begin
				prdata_o <= {16'h0000, pulse_mode_reg};
			end else if (sel == SEL_IRQ_STATUS) begin
				prdata_o <= {23'h000000, irq_status};
			end else if (sel == SEL_IRQ_ENABLE) begin
				prdata_o <= {23'h000000, irq_enable};
			end else begin
				prdata_o <= 32'h0000_0000;
			end
		end
	end

endmodule // phase_sign_regs

//--- inc/phase_sign_pkg.sv
/*
 * constants, register map and carrier types for the phase compensation
 * and power sign register bank.
 * assumes an apb master on the same clock and a power datapath that hands
 * over signed per-phase results with a one-cycle strobe on that clock.
 */
package phase_sign_pkg;

	// ----------------------------------------------------------------
	// bus and data widths
	// ----------------------------------------------------------------
	localparam int PADDR_W = 18;
	localparam int REG_W = 16;
	localparam int COMP_W = 10;
	localparam int POWER_W = 24;
	localparam int SUM_W = 26;
	localparam int SIGN_W = 9;

	// ----------------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [15:0] PHASE_A_PHASE_COMP_IDX = 16'he614;
	localparam logic [15:0] PHASE_B_PHASE_COMP_IDX = 16'he615;
	localparam logic [15:0] PHASE_C_PHASE_COMP_IDX = 16'he616;
	localparam logic [15:0] POWER_SIGN_STATUS_IDX = 16'he617;
	localparam logic [15:0] ACCUMULATION_MODE_IDX = 16'hf000;
	localparam logic [15:0] COMPENSATION_MODE_IDX = 16'hf001;
	localparam logic [15:0] PULSE_MODE_IDX = 16'hf002;
	localparam logic [15:0] IRQ_STATUS_IDX = 16'hf003;
	localparam logic [15:0] IRQ_ENABLE_IDX = 16'hf004;
	localparam logic [15:0] IRQ_CLEAR_IDX = 16'hf005;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int ACTIVE_REVERSAL_SELECT_BIT = 6;
	localparam int REACTIVE_REVERSAL_SELECT_BIT = 7;
	localparam int SUM_ONE_BIT = 3;
	localparam int SUM_TWO_BIT = 7;
	localparam int SUM_THREE_BIT = 8;
	localparam logic [COMP_W-1:0] COMP_RESET = 10'h000;
	localparam logic [REG_W-1:0] ACCUMULATION_MODE_RESET = 16'h0000;
	localparam logic [REG_W-1:0] COMPENSATION_MODE_RESET = 16'h01ff;
	localparam logic [REG_W-1:0] PULSE_MODE_RESET = 16'h0e88;
	localparam logic [SIGN_W-1:0] SIGN_RESET = 9'h000;

	// ----------------------------------------------------------------
	// compensation code ranges
	// ----------------------------------------------------------------
	localparam logic [COMP_W-1:0] LEAD_MAX = 10'h17f;
	localparam logic [COMP_W-1:0] ALIAS_LOW_MAX = 10'h1ff;
	localparam logic [COMP_W-1:0] ALIAS_LOW_SHIFT = 10'h080;
	localparam logic [COMP_W-1:0] LAG_MAX = 10'h23f;
	localparam logic [COMP_W-1:0] ALIAS_HIGH_BASE = 10'h240;
	localparam logic [COMP_W-1:0] ALIAS_HIGH_TARGET = 10'h180;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		POWER_TOTAL_ACTIVE = 3'b000,
		POWER_TOTAL_REACTIVE = 3'b001,
		POWER_APPARENT = 3'b010,
		POWER_FUND_ACTIVE = 3'b011,
		POWER_FUND_REACTIVE = 3'b100
	} power_type_t;

	typedef enum logic [3:0] {
		SEL_COMP_A = 4'b0000,
		SEL_COMP_B = 4'b0001,
		SEL_COMP_C = 4'b0010,
		SEL_SIGN = 4'b0011,
		SEL_ACC_MODE = 4'b0100,
		SEL_COMP_MODE = 4'b0101,
		SEL_PULSE_MODE = 4'b0110,
		SEL_IRQ_STATUS = 4'b0111,
		SEL_IRQ_ENABLE = 4'b1000,
		SEL_IRQ_CLEAR = 4'b1001,
		SEL_NONE = 4'b1111
	} reg_sel_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [PADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic signed [POWER_W-1:0] total_active;
		logic signed [POWER_W-1:0] fund_active;
		logic signed [POWER_W-1:0] total_reactive;
		logic signed [POWER_W-1:0] fund_reactive;
		logic signed [POWER_W-1:0] apparent;
	} phase_power_t;

	typedef phase_power_t [2:0] power_set_t;

	typedef logic [2:0][COMP_W-1:0] comp_set_t;

endpackage

//--- dv/phase_sign_properties.sv
/*
 * concurrent checks on the ports of the phase compensation and sign bank.
 * assumes one clock, async active-low reset and an apb master that holds
 * its request until pready_o.
 */
module phase_sign_props
	import phase_sign_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire phase_sign_pkg::apb_req_t apb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire phase_sign_pkg::power_set_t power_i,
	input wire logic new_result_i,
	input wire phase_sign_pkg::comp_set_t comp_effective_o,
	input wire logic [REG_W-1:0] pulse_mode_o,
	input wire logic [REG_W-1:0] compensation_mode_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import phase_sign_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic rd_done;
	logic wr_done;
	logic [15:0] idx;
	assign rd_done = pready_o && !apb_i.pwrite;
	// a refused write lands nowhere, so it must not arm the write checks
	assign wr_done = pready_o && apb_i.pwrite && !pslverr_o;
	assign idx = apb_i.paddr[17:2];
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ready_pulse;
		pready_o |=> !pready_o;
	endproperty
	property p_one_wait;
		apb_i.psel && apb_i.penable && !pready_o |=> pready_o;
	endproperty
	property p_err_with_ready;
		pslverr_o |-> pready_o;
	endproperty
	property p_misaligned;
		pready_o && apb_i.paddr[1:0] != 2'h0
			|-> pslverr_o && (apb_i.pwrite || prdata_o == 32'h0);
	endproperty
	property p_sign_upper;
		rd_done && idx == POWER_SIGN_STATUS_IDX |-> prdata_o[31:9] == 23'h0;
	endproperty
	property p_comp_upper;
		rd_done && idx >= PHASE_A_PHASE_COMP_IDX && idx <= PHASE_C_PHASE_COMP_IDX
			|-> prdata_o[31:10] == 22'h0;
	endproperty
	property p_fold_range;
		comp_effective_o[0] <= 10'h23f && comp_effective_o[1] <= 10'h23f
			&& comp_effective_o[2] <= 10'h23f;
	endproperty
	property p_lead_kept;
		wr_done && idx == PHASE_A_PHASE_COMP_IDX && apb_i.pwdata[9:0] <= 10'h17f
			|=> ##1 comp_effective_o[0] == $past(apb_i.pwdata[9:0], 2);
	endproperty
	property p_pulse_follow;
		wr_done && idx == PULSE_MODE_IDX |=> ##1 pulse_mode_o == $past(apb_i.pwdata[15:0], 2);
	endproperty
	property p_irq_mask;
		wr_done && idx == IRQ_ENABLE_IDX && apb_i.pwdata[8:0] == 9'h0 |=> ##1 !irq_o;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
	a_misaligned: assert property (p_misaligned) else $error("bad address not refused");
	a_sign_upper: assert property (p_sign_upper) else $error("sign upper bits set");
	a_comp_upper: assert property (p_comp_upper) else $error("comp upper bits set");
	a_fold_range: assert property (p_fold_range) else $error("folded code too big");
	a_lead_kept: assert property (p_lead_kept) else $error("lead code altered");
	a_pulse_follow: assert property (p_pulse_follow) else $error("pulse mode stale");
	a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
	c_err: cover property (pready_o && pslverr_o);
	c_result: cover property (new_result_i);
	c_irq: cover property (irq_o);
endmodule // phase_sign_props

bind phase_sign_regs phase_sign_props u_phase_sign_props (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.apb_i(apb_i),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.power_i(power_i),
	.new_result_i(new_result_i),
	.comp_effective_o(comp_effective_o),
	.pulse_mode_o(pulse_mode_o),
	.compensation_mode_o(compensation_mode_o),
	.irq_o(irq_o)
);

//--- dv/testbench.sv
/*
 * self-checking bench for the phase compensation and sign bank.
 * assumes the design answers apb with one wait state and takes power
 * results on a one-cycle new_result_i strobe.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import phase_sign_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	apb_req_t apb_i = '0;
	power_set_t power_i = '0;
	logic new_result_i = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic irq_o;
	comp_set_t comp_effective_o;
	logic [REG_W-1:0] pulse_mode_o;
	logic [REG_W-1:0] compensation_mode_o;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] r;
	logic e;
	power_set_t pw;

	phase_sign_regs u_phase_sign_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .power_i(power_i),
		.new_result_i(new_result_i), .comp_effective_o(comp_effective_o),
		.pulse_mode_o(pulse_mode_o), .compensation_mode_o(compensation_mode_o), .irq_o(irq_o));

	always #12.5 clk_i = ~clk_i;
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// request held until pready_o is seen high at a rising edge
	task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge clk_i);
		apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		bus(1'b1, {i, 2'b00}, d);
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] exp);
		bus(1'b0, {i, 2'b00}, 32'h0);
		chk(r, exp);
	endtask
	task automatic pulse();
		@(posedge clk_i);
		power_i <= pw;
		new_result_i <= 1'b1;
		@(posedge clk_i);
		new_result_i <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 3; i++) rd(PHASE_A_PHASE_COMP_IDX + 16'(i), 32'h0);
		rd(POWER_SIGN_STATUS_IDX, 32'h0);
		chk(32'(pulse_mode_o), 32'h0e88);
		chk(32'(compensation_mode_o), 32'h01ff);
		bus(1'b0, 18'h00004, 32'h0);
		chk({31'h0, e}, 32'h1);
		bus(1'b1, {PHASE_A_PHASE_COMP_IDX, 2'b10}, 32'h55);
		chk({31'h0, e}, 32'h1);
		rd(PHASE_A_PHASE_COMP_IDX, 32'h0);
	endtask
	task automatic t_comp();
		logic [9:0] code [8] = '{10'h000, 10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f,
			10'h240, 10'h3ff};
		logic [9:0] fold [8] = '{10'h000, 10'h17f, 10'h100, 10'h17f, 10'h200, 10'h23f,
			10'h180, 10'h1bf};
		for (int i = 0; i < 8; i++) begin
			wr(PHASE_A_PHASE_COMP_IDX + 16'(i % 3), 32'h0000fc00 | 32'(code[i]));
			rd(PHASE_A_PHASE_COMP_IDX + 16'(i % 3), 32'(code[i]));
			chk(32'(comp_effective_o[i % 3]), 32'(fold[i]));
		end
	endtask
	task automatic t_sign();
		pw[0] = '{-24'sd5, 24'sd3, 24'sd2, -24'sd4, 24'sd1};
		pw[1] = '{24'sd2, -24'sd1, -24'sd6, 24'sd1, 24'sd1};
		pw[2] = '{default: 24'sd1};
		wr(IRQ_ENABLE_IDX, 32'h1);
		pulse();
		rd(POWER_SIGN_STATUS_IDX, 32'h0a9);
		rd(IRQ_STATUS_IDX, 32'h0a9);
		chk({31'h0, irq_o}, 32'h1);
		wr(IRQ_ENABLE_IDX, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wr(IRQ_ENABLE_IDX, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(POWER_SIGN_STATUS_IDX, 32'h1ff);
		rd(POWER_SIGN_STATUS_IDX, 32'h0a9);
		wr(IRQ_CLEAR_IDX, 32'h1ff);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b0, {IRQ_CLEAR_IDX, 2'b00}, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(ACCUMULATION_MODE_IDX, 32'h0c0);
		pulse();
		rd(POWER_SIGN_STATUS_IDX, 32'h09a);
		wr(PULSE_MODE_IDX, 32'h0023);
		wr(COMPENSATION_MODE_IDX, 32'h008f);
		pulse();
		rd(POWER_SIGN_STATUS_IDX, 32'h092);
		chk(32'(pulse_mode_o), 32'h0023);
		chk(32'(compensation_mode_o), 32'h008f);
		rd(COMPENSATION_MODE_IDX, 32'h008f);
		// reserved power type on path two adds nothing, so its sum reads positive
		wr(PULSE_MODE_IDX, 32'h002b);
		pulse();
		rd(POWER_SIGN_STATUS_IDX, 32'h012);
		pw = '0;
		@(posedge clk_i);
		power_i <= pw;
		rd(POWER_SIGN_STATUS_IDX, 32'h012);
		pulse();
		rd(POWER_SIGN_STATUS_IDX, 32'h0);
	endtask
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_comp();
		t_sign();
		tally_and_finish();
	end
endmodule // testbench
